// ---- byte_wide_host_access_port.sv ----
// Byte-wide direct I/O host port with ready handshake and DMA mode
//
// Function
// R1: In direct mode the two select inputs choose the host register.
// R2: An access is valid only while the active-low port select is low.
// R3: In DMA mode selects are ignored; indirect address routes to a data register.
// R4: DMA mode with auto-increment set uses incrementing data register, address increments.
// R5: DMA mode with auto-increment clear uses plain data register, address unchanged.
// R6: Eight-bit bidirectional data bus; device drives reads, host drives writes.
// R7: Interrupt output driven; causing event held in readable interrupt status register.
// R8: On reads ready goes low once read data is valid on the bus.
// R9: On writes ready goes low after port select returns high, data captured.
// R10: Ready driven high one clock before release to high impedance.
// R11: Host holds read-not-write high for reads, low for writes.
// R12: Receive-ready high when management receive buffers are empty.
// R13: Transmit-ready is one if any end, start or transmit-control bit set.
// R14: All logic runs from the single master clock.
// R15: Reset is synchronous; state is set on a clock edge.
// R16: Data bus and ready are high impedance outside an access.
`timescale 1ns/1ns
`default_nettype none
module byte_wide_host_access_port
	import bwhp_pkg::*;
#(
	parameter int FRAME_BUFS = 4,
	parameter int TXCTL_W = 8,
	parameter int EVENT_W = 8
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic reg_select_hi,
	input wire logic reg_select_lo,
	input wire logic port_select_n,
	input wire logic dma_mode_n,
	input wire logic read_not_write,
	input wire logic [7:0] hostByteIn,
	output logic [7:0] hostByteOut,
	output logic hostByteOe,
	output logic host_irq,
	output logic host_ready_n,
	output logic hostReadyOe,
	output logic mgmt_rx_ready,
	output logic mgmt_tx_ready,
	input wire logic auto_increment_en,
	input wire logic [EVENT_W-1:0] irqEvents,
	input wire logic [FRAME_BUFS-1:0] rxBufEmpty,
	input wire logic [FRAME_BUFS-1:0] eofBits,
	input wire logic [FRAME_BUFS-1:0] sofBits,
	input wire logic [TXCTL_W-1:0] mgmt_tx_control_bits,
	input wire logic [7:0] dataRegRdIn,
	output logic [15:0] indirect_address_reg,
	output logic [7:0] dataWrByte,
	output logic dataWrPulse,
	output logic dataRdPulse,
	output logic dataIncSel
);
	bwhp_sync_if syncBus ();
	bwhp_state_type state_r, state_nxt;
	logic [7:0] rdData_r;
	logic [7:0] intStatus_r;
	logic [7:0] intStatus_nxt;
	logic [15:0] addr_r;
	logic [15:0] addr_nxt;
	logic [1:0] accSel_r;
	logic [7:0] wrData_r;
	logic dataWr_r;
	logic dataWr_nxt;
	logic dataRd_r;
	logic dataRd_nxt;
	logic incSel_r;
	logic isRead_r;
	logic [1:0] effSel;
	logic selValid;
	logic takeAccess;
	logic writeEnd;
	logic addrLoad;
	logic addrInc;
	logic accessDone;
	logic [7:0] rdMux;
	logic [7:0] evByte;
	logic intClr;
	logic isDataSel;

	// R14
	bwhp_pin_sync uSync (
		.clock(clock),
		.rst(rst),
		.regSelPin({reg_select_hi, reg_select_lo}),
		.portSelectNPin(port_select_n),
		.dmaModeNPin(dma_mode_n),
		.readNotWritePin(read_not_write),
		.hostBytePin(hostByteIn),
		.syncOut(syncBus)
	);

	assign selValid = !syncBus.portSelectN; // R2
	assign takeAccess = (state_r == ST_IDLE) && selValid;
	assign writeEnd = (state_r == ST_WRITE) && !selValid; // R9
	// R1 R3 R4 R5
	assign effSel = syncBus.dmaModeN ? syncBus.regSelect : (auto_increment_en ? SEL_DATA_INC : SEL_DATA_PLAIN);
	assign isDataSel = (accSel_r == SEL_DATA_INC) || (accSel_r == SEL_DATA_PLAIN);
	assign accessDone = (state_r == ST_ACK) && syncBus.portSelectN;
	assign addrInc = accessDone && incSel_r; // R4 R5
	assign addrLoad = writeEnd && (accSel_r == SEL_ADDR);
	assign addr_nxt = addrInc ? addr_r + 16'h0001 : {addr_r[15:8], wrData_r};
	assign rdMux = (accSel_r == SEL_INT_STATUS) ? intStatus_r :
		(accSel_r == SEL_ADDR) ? addr_r[7:0] : dataRegRdIn;
	// Status bits above the event width stay clear
	for (genvar b = 0; b < 8; b++) begin : gEvBit
		if (b < EVENT_W) begin : gUsed
			assign evByte[b] = irqEvents[b];
		end else begin : gSpare
			assign evByte[b] = 1'b0;
		end
	end
	assign intClr = (state_r == ST_READ) && (accSel_r == SEL_INT_STATUS);
	assign intStatus_nxt = (intClr ? DATA_RST : intStatus_r) | evByte;
	assign dataWr_nxt = writeEnd && isDataSel;
	assign dataRd_nxt = (state_r == ST_READ) && isDataSel;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (selValid) begin
					state_nxt = syncBus.readNotWrite ? ST_READ : ST_WRITE; // R11
				end
			end
			ST_READ: state_nxt = ST_ACK;
			ST_WRITE: begin
				if (!selValid) begin
					state_nxt = ST_ACK; // R9
				end
			end
			ST_ACK: begin
				if (syncBus.portSelectN) begin
					state_nxt = ST_RELEASE;
				end
			end
			ST_RELEASE: state_nxt = ST_IDLE; // R10
		endcase
	end

	// R15
	always_ff @(posedge clock) begin
		if (rst) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Access latches taken at the start of each access
	always_ff @(posedge clock) begin
		if (rst) begin
			accSel_r <= SEL_INT_STATUS;
			incSel_r <= 1'b0;
			isRead_r <= 1'b1;
		end else if (takeAccess) begin
			accSel_r <= effSel;
			incSel_r <= !syncBus.dmaModeN && auto_increment_en;
			isRead_r <= syncBus.readNotWrite; // R11
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdData_r <= DATA_RST;
		end else if (state_r == ST_READ) begin
			rdData_r <= rdMux; // R8
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wrData_r <= DATA_RST;
		end else if (state_r == ST_WRITE && selValid) begin
			wrData_r <= syncBus.hostByte; // R6
		end
	end

	// R7: set wins over read clear
	always_ff @(posedge clock) begin
		if (rst) begin
			intStatus_r <= DATA_RST;
		end else begin
			intStatus_r <= intStatus_nxt;
		end
	end

	// R4 R5
	always_ff @(posedge clock) begin
		if (rst) begin
			addr_r <= ADDR_RST;
		end else if (addrInc || addrLoad) begin
			addr_r <= addr_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			dataWr_r <= 1'b0;
			dataRd_r <= 1'b0;
		end else begin
			dataWr_r <= dataWr_nxt;
			dataRd_r <= dataRd_nxt;
		end
	end

	assign hostByteOut = rdData_r;
	assign hostByteOe = (state_r == ST_ACK) && isRead_r; // R6 R16
	assign host_ready_n = (state_r != ST_ACK); // R8 R9 R10
	assign hostReadyOe = (state_r == ST_ACK) || (state_r == ST_RELEASE); // R16
	assign host_irq = |intStatus_r; // R7
	assign mgmt_rx_ready = &rxBufEmpty; // R12
	assign mgmt_tx_ready = (|eofBits) || (|sofBits) || (|mgmt_tx_control_bits); // R13
	assign indirect_address_reg = addr_r; // R3
	assign dataWrByte = wrData_r;
	assign dataWrPulse = dataWr_r;
	assign dataRdPulse = dataRd_r;
	assign dataIncSel = incSel_r;
endmodule : byte_wide_host_access_port
`default_nettype wire

// ---- bwhp_pkg.sv ----
// Package with constants and types for the byte-wide host access port
package bwhp_pkg;
	localparam int DATA_W = 8;
	localparam int SEL_W = 2;
	localparam int ADDR_W = 16;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [15:0] ADDR_RST = 16'h0000;
	// Synchroniser idle levels, all pins pulled up
	localparam logic [12:0] SYNC_RST = 13'h1fff;
	// Host register selects used in direct mode; the two data selects are forced in DMA mode
	localparam logic [1:0] SEL_INT_STATUS = 2'h0;
	localparam logic [1:0] SEL_ADDR = 2'h1;
	localparam logic [1:0] SEL_DATA_INC = 2'h2;
	localparam logic [1:0] SEL_DATA_PLAIN = 2'h3;
	localparam int READ_LAT_CYC = 1;
	localparam int ACK_HIGH_CYC = 1;
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_READ = 5'b00010,
		ST_WRITE = 5'b00100,
		ST_ACK = 5'b01000,
		ST_RELEASE = 5'b10000
	} bwhp_state_type;
endpackage : bwhp_pkg

// ---- bwhp_sync_if.sv ----
// Interface carrying synchronised host pin levels
`timescale 1ns/1ns
`default_nettype none
interface bwhp_sync_if;
	logic [1:0] regSelect;
	logic portSelectN;
	logic dmaModeN;
	logic readNotWrite;
	logic [7:0] hostByte;
	modport src (output regSelect, portSelectN, dmaModeN, readNotWrite, hostByte);
	modport dst (input regSelect, portSelectN, dmaModeN, readNotWrite, hostByte);
endinterface : bwhp_sync_if
`default_nettype wire

// ---- bwhp_pin_sync.sv ----
// Two-flop synchroniser for all host input pins
`timescale 1ns/1ns
`default_nettype none
module bwhp_pin_sync
	import bwhp_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [1:0] regSelPin,
	input wire logic portSelectNPin,
	input wire logic dmaModeNPin,
	input wire logic readNotWritePin,
	input wire logic [7:0] hostBytePin,
	bwhp_sync_if.src syncOut
);
	localparam int W = 13;
	logic [W-1:0] stage1_r;
	logic [W-1:0] stage2_r;
	logic [W-1:0] pinVec;
	assign pinVec = {regSelPin, portSelectNPin, dmaModeNPin, readNotWritePin, hostBytePin};
	// Idle levels match the pullups
	always_ff @(posedge clock) begin
		if (rst) begin
			stage1_r <= SYNC_RST;
			stage2_r <= SYNC_RST;
		end else begin
			stage1_r <= pinVec;
			stage2_r <= stage1_r;
		end
	end
	assign syncOut.regSelect = stage2_r[12:11];
	assign syncOut.portSelectN = stage2_r[10];
	assign syncOut.dmaModeN = stage2_r[9];
	assign syncOut.readNotWrite = stage2_r[8];
	assign syncOut.hostByte = stage2_r[7:0];
endmodule : bwhp_pin_sync
`default_nettype wire

// ---- bwhp_asserts.sv ----
// Concurrent checks on the host port pins
`timescale 1ns/1ns
`default_nettype none
module bwhp_asserts #(parameter int FRAME_BUFS = 4, parameter int TXCTL_W = 8, parameter int EVENT_W = 8) (
	input wire logic clock,
	input wire logic rst,
	input wire logic port_select_n,
	input wire logic host_ready_n,
	input wire logic hostReadyOe,
	input wire logic hostByteOe,
	input wire logic host_irq,
	input wire logic mgmt_rx_ready,
	input wire logic mgmt_tx_ready,
	input wire logic [EVENT_W-1:0] irqEvents,
	input wire logic [FRAME_BUFS-1:0] rxBufEmpty,
	input wire logic [FRAME_BUFS-1:0] eofBits,
	input wire logic [FRAME_BUFS-1:0] sofBits,
	input wire logic [TXCTL_W-1:0] mgmt_tx_control_bits
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	rx_ready_a: assert property (mgmt_rx_ready == &rxBufEmpty)
		else $error("rx ready wrong");
	tx_ready_a: assert property (mgmt_tx_ready == (|eofBits || |sofBits || |mgmt_tx_control_bits))
		else $error("tx ready wrong");
	irq_set_a: assert property (|irqEvents |-> ##[1:2] host_irq)
		else $error("irq not raised");
	ready_rel_a: assert property ($rose(host_ready_n) && hostReadyOe |=> !hostReadyOe)
		else $error("ready high not one cycle");
	write_ack_a: assert property ($fell(host_ready_n) && !hostByteOe |-> $past(port_select_n, 2))
		else $error("write ack before select high");
	read_ack_a: assert property ($fell(host_ready_n) && hostByteOe |-> !$past(port_select_n, 2))
		else $error("read ack outside access");
	ack_hold_a: assert property (!host_ready_n && !port_select_n |=> !host_ready_n)
		else $error("ready dropped early");
	idle_z_a: assert property (!hostReadyOe |-> !hostByteOe && host_ready_n)
		else $error("bus driven when idle");
endmodule : bwhp_asserts
`default_nettype wire

// ---- bwhp_host_model.sv ----
// Host processor model driving the port pins
`timescale 1ns/1ns
`default_nettype none
module bwhp_host_model (
	input wire logic clock,
	input wire logic [7:0] hostByteOut,
	input wire logic hostByteOe,
	input wire logic host_ready_n,
	input wire logic hostReadyOe,
	output logic reg_select_hi,
	output logic reg_select_lo,
	output logic port_select_n,
	output logic read_not_write,
	output logic [7:0] hostByteIn
);
	logic [7:0] wData = 8'h00;
	logic hostDrv = 1'b0;
	int stalls = 0;
	wire logic readyLvl = hostReadyOe ? host_ready_n : 1'b1;
	assign hostByteIn = hostByteOe ? hostByteOut : (hostDrv ? wData : 8'hff);
	initial begin
		{reg_select_hi, reg_select_lo} = 2'h0;
		port_select_n = 1'b1;
		read_not_write = 1'b1;
	end
	task automatic access(input logic rnw, input logic [1:0] sel, input logic [7:0] wd, output logic [7:0] rd);
		int n;
		n = 0;
		@(negedge clock);
		{reg_select_hi, reg_select_lo} = sel;
		read_not_write = rnw;
		wData = wd;
		hostDrv = !rnw;
		port_select_n = 1'b0;
		if (!rnw) begin
			repeat (5) @(negedge clock);
			port_select_n = 1'b1;
		end
		while (readyLvl !== 1'b0 && n < 40) begin
			@(posedge clock);
			#1;
			n++;
		end
		rd = hostByteIn;
		if (readyLvl !== 1'b0) stalls++;
		repeat (2) @(negedge clock);
		port_select_n = 1'b1;
		hostDrv = 1'b0;
		n = 0;
		while (hostReadyOe !== 1'b0 && n < 40) begin
			@(negedge clock);
			n++;
		end
		if (hostReadyOe !== 1'b0) stalls++;
		repeat (3) @(negedge clock);
	endtask : access
endmodule : bwhp_host_model
`default_nettype wire

// ---- byte_wide_host_access_port_bench.sv ----
// Self-checking bench for the byte-wide host access port
`timescale 1ns/1ns
`default_nettype none
module byte_wide_host_access_port_bench;
	import bwhp_pkg::*;
	logic clock, rst, dma_mode_n, auto_increment_en;
	logic [7:0] irqEvents, dataRegRdIn, rd, mgmt_tx_control_bits;
	logic [3:0] rxBufEmpty, eofBits, sofBits;
	wire logic reg_select_hi, reg_select_lo, port_select_n, read_not_write, hostByteOe, host_irq;
	wire logic host_ready_n, hostReadyOe, mgmt_rx_ready, mgmt_tx_ready, dataWrPulse, dataRdPulse, dataIncSel;
	wire logic [7:0] hostByteIn, hostByteOut, dataWrByte;
	wire logic [15:0] indirect_address_reg;
	int miscompares = 0, checks = 0;
	int wrPulses = 0, rdPulses = 0;
	logic [21:0] rows [0:4] = '{{4'hf, 4'h0, 4'h0, 8'h00, 2'b10}, {4'h7, 4'h0, 4'h0, 8'h00, 2'b00},
		{4'h0, 4'h1, 4'h0, 8'h00, 2'b01}, {4'hf, 4'h0, 4'h8, 8'h00, 2'b11}, {4'h0, 4'h0, 4'h0, 8'h80, 2'b01}};
	byte_wide_host_access_port dut (
		.clock(clock),
		.rst(rst),
		.reg_select_hi(reg_select_hi),
		.reg_select_lo(reg_select_lo),
		.port_select_n(port_select_n),
		.dma_mode_n(dma_mode_n),
		.read_not_write(read_not_write),
		.hostByteIn(hostByteIn),
		.hostByteOut(hostByteOut),
		.hostByteOe(hostByteOe),
		.host_irq(host_irq),
		.host_ready_n(host_ready_n),
		.hostReadyOe(hostReadyOe),
		.mgmt_rx_ready(mgmt_rx_ready),
		.mgmt_tx_ready(mgmt_tx_ready),
		.auto_increment_en(auto_increment_en),
		.irqEvents(irqEvents),
		.rxBufEmpty(rxBufEmpty),
		.eofBits(eofBits),
		.sofBits(sofBits),
		.mgmt_tx_control_bits(mgmt_tx_control_bits),
		.dataRegRdIn(dataRegRdIn),
		.indirect_address_reg(indirect_address_reg),
		.dataWrByte(dataWrByte),
		.dataWrPulse(dataWrPulse),
		.dataRdPulse(dataRdPulse),
		.dataIncSel(dataIncSel)
	);
	bwhp_host_model host (
		.clock(clock),
		.hostByteOut(hostByteOut),
		.hostByteOe(hostByteOe),
		.host_ready_n(host_ready_n),
		.hostReadyOe(hostReadyOe),
		.reg_select_hi(reg_select_hi),
		.reg_select_lo(reg_select_lo),
		.port_select_n(port_select_n),
		.read_not_write(read_not_write),
		.hostByteIn(hostByteIn)
	);
	// Data register strobes, counted away from the launching edge
	always @(negedge clock) begin
		if (dataWrPulse === 1'b1) wrPulses++;
		if (dataRdPulse === 1'b1) rdPulses++;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	initial begin
		#(4000 * 100);
		miscompares++;
		end_sim();
	end
	initial begin
		{rst, dma_mode_n, auto_increment_en, irqEvents, dataRegRdIn} = {2'b11, 1'b0, 8'h00, 8'hc3};
		{rxBufEmpty, eofBits, sofBits, mgmt_tx_control_bits} = 20'h00000;
		repeat (10) @(negedge clock);
		chk(16'({host_ready_n, hostReadyOe, host_irq}), 16'h0004);
		chk(indirect_address_reg, 16'h0000);
		rst = 1'b0;
		for (int i = 0; i < 5; i++) begin
			@(negedge clock);
			{rxBufEmpty, eofBits, sofBits, mgmt_tx_control_bits} = rows[i][21:2];
			#1 chk(16'({mgmt_rx_ready, mgmt_tx_ready}), 16'(rows[i][1:0]));
		end
		host.access(1'b0, SEL_ADDR, 8'h5a, rd);
		chk(indirect_address_reg, 16'h005a);
		host.access(1'b1, SEL_DATA_PLAIN, 8'h00, rd);
		chk(16'(rd), 16'h00c3);
		@(negedge clock);
		{dma_mode_n, auto_increment_en} = 2'b01;
		host.access(1'b1, SEL_ADDR, 8'h00, rd);
		chk(16'(rd), 16'h00c3);
		chk(indirect_address_reg, 16'h005b);
		chk(16'({dataIncSel, 4'(rdPulses)}), 16'h0012);
		auto_increment_en = 1'b0;
		host.access(1'b0, SEL_ADDR, 8'h77, rd);
		chk(16'({dataWrByte, indirect_address_reg[7:0]}), 16'h775b);
		chk(16'({dataIncSel, 4'(wrPulses)}), 16'h0001);
		{dma_mode_n, irqEvents} = {1'b1, 8'h04};
		@(negedge clock);
		irqEvents = 8'h00;
		repeat (2) @(negedge clock);
		chk(16'(host_irq), 16'h0001);
		host.access(1'b1, SEL_INT_STATUS, 8'h00, rd);
		chk(16'({rd, 7'h00, host_irq}), 16'h0400);
		irqEvents = 8'h01;
		@(negedge clock);
		irqEvents = 8'h00;
		chk(16'(host_irq), 16'h0001);
		rst = 1'b1;
		repeat (3) @(negedge clock);
		chk(16'({host_ready_n, hostReadyOe, host_irq}), 16'h0004);
		chk(indirect_address_reg, 16'h0000);
		rst = 1'b0;
		host.access(1'b1, SEL_ADDR, 8'h00, rd);
		chk(16'({rd, 4'(rdPulses), 4'(wrPulses)}), 16'h0021);
		chk(16'(host.stalls), 16'h0000);
		end_sim();
	end
endmodule : byte_wide_host_access_port_bench
bind byte_wide_host_access_port bwhp_asserts #(.FRAME_BUFS(FRAME_BUFS), .TXCTL_W(TXCTL_W), .EVENT_W(EVENT_W)) chk_u (
	.clock(clock),
	.rst(rst),
	.port_select_n(port_select_n),
	.host_ready_n(host_ready_n),
	.hostReadyOe(hostReadyOe),
	.hostByteOe(hostByteOe),
	.host_irq(host_irq),
	.mgmt_rx_ready(mgmt_rx_ready),
	.mgmt_tx_ready(mgmt_tx_ready),
	.irqEvents(irqEvents),
	.rxBufEmpty(rxBufEmpty),
	.eofBits(eofBits),
	.sofBits(sofBits),
	.mgmt_tx_control_bits(mgmt_tx_control_bits)
);
`default_nettype wire
